// ===== rtl/pdg_defs.svh
// offsets, field positions, reset values and divider widths of the pulse generator
`ifndef PDG_DEFS_SVH
`define PDG_DEFS_SVH
// ==========================================
// register offsets
`define PDG_OFS_PAIR     4'h0
`define PDG_OFS_CFG      4'h1
`define PDG_OFS_CYC_LO   4'h2
`define PDG_OFS_CYC_HI   4'h3
`define PDG_OFS_DUTY_LO  4'h4
`define PDG_OFS_DUTY_HI  4'h5
`define PDG_OFS_CLKSYS   4'h6
`define PDG_OFS_STATUS   4'h7
`define PDG_OFS_MASK     4'h8
`define PDG_OFS_CNT_LO   4'h9
`define PDG_OFS_CNT_HI   4'ha
// ==========================================
// field positions
`define PDG_BIT_CASCADE  0
`define PDG_BIT_RUN      1
`define PDG_FLD_MODE     1:0
`define PDG_FLD_DIV      4:2
`define PDG_BIT_EXTSRC   5
`define PDG_BIT_INITLVL  6
`define PDG_BIT_DBUF     7
`define PDG_BIT_DVSRC    0
`define PDG_BIT_SLOW     1
`define PDG_BIT_IRQ_DUTY 0
`define PDG_BIT_IRQ_CYC  1
// ==========================================
// encodings and reset values
`define PDG_MODE_PPG16   2'h3
`define PDG_RST_CTRL     8'h00
`define PDG_RST_VALUE    8'hff
`define PDG_GEAR_W       11
`define PDG_LOW_W        4
`endif

// ===== rtl/pdg_pkg.sv
// types shared by the pulse generator files
`default_nettype none
package pdg_pkg;
   // ==========================================
   // control states, gray coded
   typedef enum logic [1:0] {
      PDG_IDLE = 2'b00,
      PDG_RUN  = 2'b01
   } pdg_state_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pdg_bus_req_t;

   // state of the top module, apart from its two prescaler counters
   typedef struct packed {
      pdg_state_t  state;
      logic [7:0]  pair;
      logic [7:0]  cfg;
      logic [7:0]  clksys;
      logic [7:0]  cyc_lo;
      logic [7:0]  cyc_hi;
      logic [7:0]  duty_lo;
      logic [7:0]  duty_hi;
      logic [15:0] buf_cyc;
      logic [15:0] buf_duty;
      logic        pending;
      logic [15:0] act_cyc;
      logic [15:0] act_duty;
      logic [15:0] cnt;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        pin;
      logic        irq;
      logic        duty_pulse;
      logic        cycle_pulse;
      logic [7:0]  rdata;
      logic [2:0]  ext_s;
      logic [2:0]  low_s;
   } pdg_top_state_t;
endpackage
`default_nettype wire

// ===== rtl/pdg_counter.sv
// free running binary counter advanced by an enable
`timescale 1ns/1ps
`default_nettype none
module pdg_counter #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         reset_i,
   // count enable
   input  wire logic         en_i,
   // count value
   output logic [W-1:0]      q_o
);
   logic [W-1:0] next_q;

   // advance on enable
   always_comb begin
      next_q = q_o;
      if (en_i) begin
         next_q = q_o + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // register
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         q_o <= '0;
      end else begin
         q_o <= next_q;
      end
   end
endmodule // pdg_counter
`default_nettype wire

// ===== rtl/pdg_pulse_gen.sv
// cascaded 16-bit programmable pulse generator with register port and interrupt
// ==========================================
// Overview of operation
// - cascade bit joins channels; upper settings only
// - mode field 11 selects 16-bit pulse mode
// - source bit picks divided clock or pin edges
// - buffer enable bit buffers compare value updates
// - high byte register supplies value high byte
// - duty high write commits all four bytes
// - stopped pin shows the initial level bit
// - duty match inverts level, cycle match restores
// - run bit counts once per source clock
// - duty match toggles pin, raises duty request
// - cycle match toggles back, requests, clears counter
// - clearing run stops, zeroes, restores idle level
// - divider codes select gear or low clock
// - buffered values load at next cycle match
// - unbuffered or stopped commit applies immediately
// ==========================================
// register map, one byte each
// 0 pair control: b0 cascade_select, b1 upper_run_control
// 1 upper_channel_config: [1:0] upper_operating_mode
//   [4:2] upper_clock_divider_sel, b5 upper_clock_source_sel
//   b6 output_initial_level, b7 compare_buffer_enable
// 2 cycle_low_byte, staged until the commit
// 3 cycle_high_byte, staged until the commit
// 4 duty_low_byte, staged until the commit
// 5 duty_high_byte, its write commits all four bytes
// 6 clock system: b0 divider_source_select, b1 slow mode
// 7 status, write one to clear: b0 duty match, b1 cycle match
// 8 interrupt mask, same layout as status
// 9 counter low byte, read only
// a counter high byte, read only
// staged bytes read back as written, not the active values
// unmapped reads give zero, unmapped writes are dropped
// ==========================================
// timing seen from the register port
// a write lands at the edge that samples it
// read data stand only in the cycle after the read strobe
// counting starts two edges after the run write lands
// a run clear stops and zeroes the counter one edge later
// pin and match pulses follow their counting tick by one edge
// status bits rise with the match pulses, irq in the same cycle
// pins pass two flops before their rising edges are taken
// ==========================================
// limitations
// the lower channel's own settings are not modelled
// the pin's port assignment sits outside this block
// in slow mode, divider codes other than 000, 001 and 111 give no ticks
// a count pin phase shorter than one cycle may be lost
// a held update is applied at stop, so a restart uses it
`timescale 1ns/1ps
`default_nettype none
`include "pdg_defs.svh"
module pdg_pulse_gen (
   // clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   // register port
   input  wire pdg_pkg::pdg_bus_req_t bus_i,
   output logic [7:0]                rdata_o,
   // clock and count pins
   input  wire logic                 low_freq_clock_i,
   input  wire logic                 external_count_input_i,
   // pulse output and interrupts
   output logic                      pulse_output_pin_o,
   output logic                      duty_match_irq_o,
   output logic                      cycle_match_irq_o,
   output logic                      irq_o
);
   // ==========================================
   // state and prescalers
   pdg_pkg::pdg_top_state_t s;
   pdg_pkg::pdg_top_state_t next_s;
   logic [`PDG_GEAR_W-1:0]  gear_cnt;
   logic [`PDG_LOW_W-1:0]   low_cnt;
   logic                    low_edge;
   logic                    ext_edge;
   logic                    gear_tick;
   logic                    src_tick;
   logic                    running;
   logic                    duty_hit;
   logic                    cyc_hit;
   logic                    commit;
   logic [1:0]              w1c;
   logic [1:0]              events;
   logic [2:0]              div;

   // gear clock divider, free running
   pdg_counter #(.W(`PDG_GEAR_W)) u_gear (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .en_i      (1'b1),
      .q_o       (gear_cnt)
   );

   // low clock divider, advanced by synchronised low clock edges
   pdg_counter #(.W(`PDG_LOW_W)) u_low (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .en_i      (low_edge),
      .q_o       (low_cnt)
   );

   // ==========================================
   // edges of synchronised pins, read after the second flop
   assign low_edge = s.low_s[1] & ~s.low_s[2];
   assign ext_edge = s.ext_s[1] & ~s.ext_s[2];
   assign div      = s.cfg[`PDG_FLD_DIV];

   // upper channel settings only, lower channel ignored
   assign running = s.pair[`PDG_BIT_RUN] & s.pair[`PDG_BIT_CASCADE]
                  & (s.cfg[`PDG_FLD_MODE] == `PDG_MODE_PPG16);

   // divider select for the gear clock
   always_comb begin
      case (div)
         3'h0:    gear_tick = &gear_cnt[10:0];
         3'h1:    gear_tick = &gear_cnt[9:0];
         3'h2:    gear_tick = &gear_cnt[7:0];
         3'h3:    gear_tick = &gear_cnt[5:0];
         3'h4:    gear_tick = &gear_cnt[3:0];
         3'h5:    gear_tick = &gear_cnt[1:0];
         3'h6:    gear_tick = gear_cnt[0];
         default: gear_tick = 1'b1;
      endcase
   end

   // source clock choice: pin edges, low clock taps or gear taps
   always_comb begin
      src_tick = 1'b0;
      if (s.cfg[`PDG_BIT_EXTSRC]) begin
         src_tick = ext_edge;
      end else if (s.clksys[`PDG_BIT_SLOW]) begin
         // slow mode: only the low clock taps count
         case (div)
            3'h0:    src_tick = low_edge & (&low_cnt[3:0]);
            3'h1:    src_tick = low_edge & (&low_cnt[2:0]);
            3'h7:    src_tick = low_edge & (&low_cnt[1:0]);
            default: src_tick = 1'b0;
         endcase
      end else if (s.clksys[`PDG_BIT_DVSRC] && (div == 3'h0)) begin
         src_tick = low_edge & (&low_cnt[3:0]);
      end else if (s.clksys[`PDG_BIT_DVSRC] && (div == 3'h1)) begin
         src_tick = low_edge & (&low_cnt[2:0]);
      end else begin
         src_tick = gear_tick;
      end
   end

   // full 16-bit compares on the current count
   assign duty_hit = (s.cnt == s.act_duty);
   assign cyc_hit  = (s.cnt == s.act_cyc);
   assign commit   = bus_i.wr && (bus_i.addr == `PDG_OFS_DUTY_HI);
   assign w1c      = (bus_i.wr && (bus_i.addr == `PDG_OFS_STATUS)) ? bus_i.wdata[1:0] : 2'h0;

   // ==========================================
   // next state
   always_comb begin
      next_s             = s;
      events             = 2'h0;
      next_s.duty_pulse  = 1'b0;
      next_s.cycle_pulse = 1'b0;
      next_s.rdata       = 8'h00;
      // pins shift through their synchroniser flops
      next_s.ext_s       = {s.ext_s[1:0], external_count_input_i};
      next_s.low_s       = {s.low_s[1:0], low_freq_clock_i};

      // register writes, staged bytes held until the commit
      if (bus_i.wr) begin
         case (bus_i.addr)
            `PDG_OFS_PAIR:    next_s.pair    = bus_i.wdata;
            `PDG_OFS_CFG:     next_s.cfg     = bus_i.wdata;
            `PDG_OFS_CYC_LO:  next_s.cyc_lo  = bus_i.wdata;
            `PDG_OFS_CYC_HI:  next_s.cyc_hi  = bus_i.wdata;
            `PDG_OFS_DUTY_LO: next_s.duty_lo = bus_i.wdata;
            `PDG_OFS_DUTY_HI: next_s.duty_hi = bus_i.wdata;
            `PDG_OFS_CLKSYS:  next_s.clksys  = bus_i.wdata;
            `PDG_OFS_MASK:    next_s.mask    = bus_i.wdata[1:0];
            default:          next_s.mask    = s.mask;
         endcase
      end

      // register reads, answered next cycle
      if (bus_i.rd) begin
         case (bus_i.addr)
            `PDG_OFS_PAIR:    next_s.rdata = s.pair;
            `PDG_OFS_CFG:     next_s.rdata = s.cfg;
            `PDG_OFS_CYC_LO:  next_s.rdata = s.cyc_lo;
            `PDG_OFS_CYC_HI:  next_s.rdata = s.cyc_hi;
            `PDG_OFS_DUTY_LO: next_s.rdata = s.duty_lo;
            `PDG_OFS_DUTY_HI: next_s.rdata = s.duty_hi;
            `PDG_OFS_CLKSYS:  next_s.rdata = s.clksys;
            `PDG_OFS_STATUS:  next_s.rdata = {6'h00, s.status};
            `PDG_OFS_MASK:    next_s.rdata = {6'h00, s.mask};
            `PDG_OFS_CNT_LO:  next_s.rdata = s.cnt[7:0];
            `PDG_OFS_CNT_HI:  next_s.rdata = s.cnt[15:8];
            default:          next_s.rdata = 8'h00;
         endcase
      end

      // counter and pin control
      case (s.state)
         // idle: counter parked at zero, pin at the chosen level
         pdg_pkg::PDG_IDLE: begin
            next_s.cnt = 16'h0000;
            next_s.pin = s.cfg[`PDG_BIT_INITLVL];
            if (running) begin
               next_s.state = pdg_pkg::PDG_RUN;
            end
         end
         pdg_pkg::PDG_RUN: begin
            if (!running) begin
               // stop: zero, idle level, flush any held update
               next_s.state = pdg_pkg::PDG_IDLE;
               next_s.cnt   = 16'h0000;
               next_s.pin   = s.cfg[`PDG_BIT_INITLVL];
               if (s.pending) begin
                  next_s.act_cyc  = s.buf_cyc;
                  next_s.act_duty = s.buf_duty;
                  next_s.pending  = 1'b0;
               end
            end else if (src_tick) begin
               next_s.cnt = s.cnt + 16'h0001;
               if (duty_hit) begin
                  // duty first, continue counting
                  next_s.pin = ~s.cfg[`PDG_BIT_INITLVL];
                  events[`PDG_BIT_IRQ_DUTY] = 1'b1;
               end
               if (cyc_hit) begin
                  next_s.pin = s.cfg[`PDG_BIT_INITLVL];
                  events[`PDG_BIT_IRQ_CYC] = 1'b1;
                  next_s.cnt = 16'h0000;
                  if (s.pending) begin
                     next_s.act_cyc  = s.buf_cyc;
                     next_s.act_duty = s.buf_duty;
                     next_s.pending  = 1'b0;
                  end
               end
            end
         end
         default: begin
            next_s.state = pdg_pkg::PDG_IDLE;
         end
      endcase

      // commit of all four bytes, high byte from the upper register
      // a buffered commit meeting a cycle match keeps its values for the later match
      if (commit) begin
         next_s.buf_cyc  = {s.cyc_hi, s.cyc_lo};
         next_s.buf_duty = {bus_i.wdata, s.duty_lo};
         if (s.cfg[`PDG_BIT_DBUF] && running && (s.state == pdg_pkg::PDG_RUN)) begin
            next_s.pending = 1'b1;
         end else begin
            next_s.act_cyc  = {s.cyc_hi, s.cyc_lo};
            next_s.act_duty = {bus_i.wdata, s.duty_lo};
            next_s.pending  = 1'b0;
         end
      end

      // sticky status, set wins over write-one clear
      next_s.status      = events | (s.status & ~w1c);
      next_s.duty_pulse  = events[`PDG_BIT_IRQ_DUTY];
      next_s.cycle_pulse = events[`PDG_BIT_IRQ_CYC];
      next_s.irq         = |(next_s.status & next_s.mask);
   end

   // ==========================================
   // state register
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         // value bytes reset to all ones, far from any early match
         s          <= '0;
         s.state    <= pdg_pkg::PDG_IDLE;
         s.pair     <= `PDG_RST_CTRL;
         s.cfg      <= `PDG_RST_CTRL;
         s.clksys   <= `PDG_RST_CTRL;
         s.cyc_lo   <= `PDG_RST_VALUE;
         s.cyc_hi   <= `PDG_RST_VALUE;
         s.duty_lo  <= `PDG_RST_VALUE;
         s.duty_hi  <= `PDG_RST_VALUE;
         s.buf_cyc  <= {`PDG_RST_VALUE, `PDG_RST_VALUE};
         s.buf_duty <= {`PDG_RST_VALUE, `PDG_RST_VALUE};
         s.act_cyc  <= {`PDG_RST_VALUE, `PDG_RST_VALUE};
         s.act_duty <= {`PDG_RST_VALUE, `PDG_RST_VALUE};
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flops
   assign rdata_o            = s.rdata;
   assign pulse_output_pin_o = s.pin;
   assign duty_match_irq_o   = s.duty_pulse;
   assign cycle_match_irq_o  = s.cycle_pulse;
   assign irq_o              = s.irq;
endmodule // pdg_pulse_gen
`default_nettype wire

// ===== tb/pdg_far_end.sv
// far side model: low frequency clock and external count pulses into the block
`timescale 1ns/1ps
`default_nettype none
module pdg_far_end (
   // clock
   input  wire logic sys_clk_i,
   // count pulse enable
   input  wire logic ext_en_i,
   // clocks toward the block
   output logic      low_freq_clock_o,
   output logic      ext_count_o
);
   logic [1:0] lf_cnt;
   logic [1:0] ext_cnt;

   // ==========================================
   // start quiet
   initial begin
      low_freq_clock_o = 1'b0;
      ext_count_o = 1'b0;
      lf_cnt = 2'h0;
      ext_cnt = 2'h0;
   end

   // low clock period 8, count input period 6, held still when disabled
   always @(posedge sys_clk_i) begin
      lf_cnt <= lf_cnt + 2'h1;
      if (lf_cnt == 2'h3) low_freq_clock_o <= !low_freq_clock_o;
      ext_cnt <= (ext_cnt == 2'h2 || !ext_en_i) ? 2'h0 : ext_cnt + 2'h1;
      if (ext_en_i && ext_cnt == 2'h2) ext_count_o <= !ext_count_o;
   end
endmodule  // pdg_far_end
`default_nettype wire

// ===== tb/pdg_checker.sv
// port assertions for the pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "pdg_defs.svh"
module pdg_checker (
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_i,
   // register port
   input  wire pdg_pkg::pdg_bus_req_t bus_i,
   input  wire logic [7:0]            rdata_o,
   // pins and requests
   input  wire logic                  low_freq_clock_i,
   input  wire logic                  external_count_input_i,
   input  wire logic                  pulse_output_pin_o,
   input  wire logic                  duty_match_irq_o,
   input  wire logic                  cycle_match_irq_o,
   input  wire logic                  irq_o
);
   logic [7:0] pair;
   logic [7:0] cfg;
   logic [1:0] mask;
   logic [1:0] st;
   wire        run = pair[1] & pair[0] & (cfg[1:0] == 2'h3);
   wire        lvl = cfg[6];
   wire  [1:0] st_now = st | {cycle_match_irq_o, duty_match_irq_o};

   // ==========================================
   // shadow of control, mask and sticky status
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pair <= 8'h00;
         cfg  <= 8'h00;
         mask <= 2'h0;
         st   <= 2'h0;
      end else begin
         st <= st_now & ~((bus_i.wr && bus_i.addr == `PDG_OFS_STATUS) ? bus_i.wdata[1:0] : 2'h0);
         if (bus_i.wr && bus_i.addr == `PDG_OFS_PAIR) pair <= bus_i.wdata;
         if (bus_i.wr && bus_i.addr == `PDG_OFS_CFG) cfg <= bus_i.wdata;
         if (bus_i.wr && bus_i.addr == `PDG_OFS_MASK) mask <= bus_i.wdata[1:0];
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   // ==========================================
   // assertions
   rd_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data not zero outside read");
   cfg_read_a: assert property (bus_i.rd && bus_i.addr == `PDG_OFS_CFG |=> rdata_o == cfg)
      else $error("config read back wrong");
   duty_pin_a: assert property (duty_match_irq_o && !cycle_match_irq_o |-> pulse_output_pin_o == !lvl)
      else $error("pin not inverted at duty match");
   cyc_pin_a: assert property (cycle_match_irq_o |-> pulse_output_pin_o == lvl)
      else $error("pin not restored at cycle match");
   idle_pin_a: assert property ((!run && !bus_i.wr)[*3] |-> pulse_output_pin_o == lvl)
      else $error("stopped pin not at initial level");
   stop_quiet_a: assert property ((!run)[*3] |-> !duty_match_irq_o && !cycle_match_irq_o)
      else $error("match request while stopped");
   irq_level_a: assert property (!$past(bus_i.wr) |-> irq_o == |(st_now & mask))
      else $error("interrupt level wrong");
   ext_quiet_a: assert property ((run && cfg[5] && $stable(external_count_input_i))[*6]
      |-> !duty_match_irq_o && !cycle_match_irq_o)
      else $error("count without external edge");
   pin_match_a: assert property (run && $past(run) && $past(run, 2) && $stable(lvl)
      && $changed(pulse_output_pin_o) |-> duty_match_irq_o || cycle_match_irq_o)
      else $error("pin moved without a match");

   // main scenarios reached
   cover property (duty_match_irq_o && !cycle_match_irq_o);
   cover property (cycle_match_irq_o ##1 !cycle_match_irq_o);
   cover property ($rose(irq_o));
endmodule  // pdg_checker

bind pdg_pulse_gen pdg_checker chk (.sys_clk_i, .reset_i, .bus_i, .rdata_o, .low_freq_clock_i,
   .external_count_input_i, .pulse_output_pin_o, .duty_match_irq_o, .cycle_match_irq_o, .irq_o);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the cascaded pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "pdg_defs.svh"
module tb;
   logic                  sys_clk_i = 1'b0;
   logic                  reset_i = 1'b1;
   pdg_pkg::pdg_bus_req_t bus_i = '0;
   logic                  ext_en = 1'b0;
   logic [7:0]            rdata_o;
   logic                  lf_clk, ext_clk, pin, d_irq, c_irq, irq;
   int                    n_fail = 0;
   int                    samples_checked = 0;
   int                    cycles = 0;
   int                    n;
   int                    shf[8] = '{11, 10, 8, 6, 4, 2, 1, 0};

   pdg_pulse_gen uut (.sys_clk_i, .reset_i, .bus_i, .rdata_o, .low_freq_clock_i(lf_clk),
      .external_count_input_i(ext_clk), .pulse_output_pin_o(pin), .duty_match_irq_o(d_irq),
      .cycle_match_irq_o(c_irq), .irq_o(irq));
   pdg_far_end far (.sys_clk_i, .ext_en_i(ext_en), .low_freq_clock_o(lf_clk), .ext_count_o(ext_clk));

   // ==========================================
   // clock and hang guard
   initial forever #4 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================
   // register port cycles, each ends just past its edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      bus_i.wr <= 1'b1;
      @(posedge sys_clk_i);
      bus_i.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge sys_clk_i);
      bus_i.rd <= 1'b0;
      #1 chk({8'h00, rdata_o}, {8'h00, exp});
   endtask

   // cycles to the next duty (0) or cycle (1) pulse; exp 0 only syncs
   task automatic wait_p(input logic cyc, input int exp);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1 n++;
      end while ((cyc ? c_irq : d_irq) !== 1'b1 && n < 12000);
      if (exp > 0 || n == 12000) chk(n[15:0], exp[15:0]);
   endtask

   task automatic commit(input logic [15:0] cyc, input logic [15:0] duty);
      wr(`PDG_OFS_CYC_LO, cyc[7:0]);
      wr(`PDG_OFS_CYC_HI, cyc[15:8]);
      wr(`PDG_OFS_DUTY_LO, duty[7:0]);
      wr(`PDG_OFS_DUTY_HI, duty[15:8]);
   endtask

   task automatic quiet(input logic [7:0] c, input logic [7:0] p);
      wr(`PDG_OFS_CFG, c);
      wr(`PDG_OFS_PAIR, p);
      repeat (8) @(posedge sys_clk_i);
      rd(`PDG_OFS_CNT_LO, 8'h00);
   endtask

   // period of four ticks at one clock choice, duty 1 and cycle 3
   task automatic div_case(input logic [7:0] clks, input logic [2:0] code, input int per);
      wr(`PDG_OFS_PAIR, 8'h01);
      wr(`PDG_OFS_CLKSYS, clks);
      wr(`PDG_OFS_CFG, {3'h0, code, 2'h3});
      wr(`PDG_OFS_PAIR, 8'h03);
      wait_p(1, 0);
      wait_p(1, per);
   endtask

   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      rd(`PDG_OFS_PAIR, 8'h00);
      rd(`PDG_OFS_CYC_HI, 8'hff);
      rd(4'hf, 8'h00);
      commit(16'h0003, 16'h0001);
      rd(`PDG_OFS_CYC_LO, 8'h03);
      wr(`PDG_OFS_CFG, 8'h1f);
      wr(`PDG_OFS_PAIR, 8'h03);
      wait_p(1, 0);
      wait_p(0, 2);
      chk(16'(pin), 16'h1);
      wait_p(1, 2);
      wait_p(1, 4);
      // stop, counter cleared, status masked then cleared
      wr(`PDG_OFS_PAIR, 8'h01);
      @(posedge sys_clk_i);  // stop lands one edge after the write
      rd(`PDG_OFS_CNT_LO, 8'h00);
      rd(`PDG_OFS_CNT_HI, 8'h00);
      chk({15'h0, pin}, 16'h0);
      rd(`PDG_OFS_STATUS, 8'h03);
      chk(16'(irq), 16'h0);
      wr(`PDG_OFS_MASK, 8'h02);
      rd(`PDG_OFS_MASK, 8'h02);
      chk(16'(irq), 16'h1);
      wr(`PDG_OFS_STATUS, 8'h02);
      rd(`PDG_OFS_STATUS, 8'h01);
      chk(16'(irq), 16'h0);
      // buffered update waits for the next cycle match
      wr(`PDG_OFS_CFG, 8'h9f);
      wr(`PDG_OFS_PAIR, 8'h03);
      wait_p(0, 0);
      commit(16'h0007, 16'h0002);
      wait_p(1, 2);
      wait_p(0, 3);
      wait_p(1, 5);
      // unbuffered update at once, inverted level, 16-bit values
      wr(`PDG_OFS_PAIR, 8'h01);
      wr(`PDG_OFS_CFG, 8'h5f);
      wr(`PDG_OFS_PAIR, 8'h03);
      wait_p(0, 0);
      commit(16'h0104, 16'h0100);
      wait_p(0, 0);
      chk(16'(pin), 16'h0);
      wait_p(1, 4);
      wr(`PDG_OFS_PAIR, 8'h01);
      @(posedge sys_clk_i);  // stop lands one edge after the write
      rd(`PDG_OFS_CNT_LO, 8'h00);
      rd(`PDG_OFS_CNT_HI, 8'h00);
      chk(16'(pin), 16'h1);
      // duty equal to cycle: both requests at once, pin stays at the initial level
      commit(16'h0003, 16'h0003);
      wr(`PDG_OFS_PAIR, 8'h03);
      wait_p(1, 0);
      wait_p(1, 4);
      chk(16'(d_irq), 16'h1);
      chk(16'(pin), 16'h1);
      wr(`PDG_OFS_PAIR, 8'h01);
      // no count without cascade, mode 11 or source edges
      commit(16'h0003, 16'h0001);
      quiet(8'h1e, 8'h03);
      quiet(8'h1f, 8'h02);
      quiet(8'h3f, 8'h03);
      ext_en <= 1'b1;
      wait_p(1, 0);
      wait_p(1, 24);
      ext_en <= 1'b0;
      // every divider code, then the low clock choices
      for (int i = 0; i < 8; i++) div_case(8'h00, 3'(i), 4 << shf[i]);
      div_case(8'h01, 3'h0, 512);
      div_case(8'h01, 3'h1, 256);
      div_case(8'h02, 3'h7, 128);
      tally_and_finish();
   end
endmodule  // tb
`default_nettype wire
